// ---- src/gpio_io_pkg.sv ----
// Purpose: Shared constants and carrier types of the pin and I/O supply block.
// Assumes: APB with 32-bit data; register index = byte address / 4.
// Notes:   Registers are 8 bits wide and sit in the low byte lane.
package gpio_io_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_RX_PORT_CONTROL  = 10'h00C;
  localparam logic [9:0] IDX_IO_VOLTAGE       = 10'h00D;
  localparam logic [9:0] IDX_PIN_LEVEL_STATUS = 10'h00E;
  localparam logic [9:0] IDX_PIN_INPUT_ENABLE = 10'h00F;
  localparam logic [9:0] IDX_PIN0_OUTPUT      = 10'h010;

  // Reset values
  localparam logic [3:0] RST_RX_PORT_ENABLE   = 4'hF;
  localparam logic [7:0] RST_PIN_INPUT_ENABLE = 8'hFF;
  localparam logic [3:0] IO_VOLTAGE_LOW_BITS  = 4'h9;  // Read-only low nibble

  // Field positions of the I/O voltage register
  localparam int IO_HIGH_SEL_BIT   = 7;
  localparam int IO_OVERRIDE_BIT   = 6;
  localparam int IO_MODE_LSB       = 4;

  // Field positions of the pin 0 output register
  localparam int PIN0_ENABLE_BIT   = 0;
  localparam int PIN0_LEVEL_BIT    = 1;
  localparam int PIN0_SOURCE_LSB   = 2;
  localparam int PIN0_SELECT_LSB   = 5;

  // Supply mode codes
  localparam logic [1:0] MODE_LOW_VOLT  = 2'h0;  // 1.8 V
  localparam logic [1:0] MODE_HIGH_VOLT = 2'h3;  // 3.3 V

  // Pin 0 source codes; 000 to 011 are the receive ports
  localparam logic [2:0] SRC_DEVICE   = 3'h4;
  localparam logic [2:0] SRC_RESERVED = 3'h5;
  localparam logic [2:0] SRC_TX0      = 3'h6;
  localparam logic [2:0] SRC_TX1      = 3'h7;

  // Select codes per source kind
  localparam logic [2:0] RXSEL_LOCK   = 3'h4;
  localparam logic [2:0] RXSEL_PASS   = 3'h5;
  localparam logic [2:0] RXSEL_FRAME  = 3'h6;
  localparam logic [2:0] RXSEL_LINE   = 3'h7;
  localparam logic [2:0] DEVSEL_VALUE = 3'h0;
  localparam logic [2:0] DEVSEL_LOCK  = 3'h1;
  localparam logic [2:0] DEVSEL_PASSA = 3'h2;
  localparam logic [2:0] DEVSEL_PASSB = 3'h3;
  localparam logic [2:0] DEVSEL_SYNC  = 3'h4;
  localparam logic [2:0] TXSEL_PASS_AND = 3'h0;
  localparam logic [2:0] TXSEL_PASS_OR  = 3'h1;
  localparam logic [2:0] TXSEL_FRAME    = 3'h2;
  localparam logic [2:0] TXSEL_LINE     = 3'h3;
  localparam logic [2:0] TXSEL_SYNCED   = 3'h4;
  localparam logic [2:0] TXSEL_INTR     = 3'h5;

  // Status of one receive port
  typedef struct packed {
    logic [3:0] remote_pins;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } rx_status_type;

  // Status of one video transmit port, with the receive ports it draws on
  typedef struct packed {
    logic [3:0] rx_select;
    logic       frame_valid;
    logic       line_valid;
    logic       synchronized;
    logic       interrupt;
  } tx_status_type;

endpackage

// ---- src/pin0_source_mux.sv ----
// Purpose: Picks the pin 0 level from receive ports, device status or transmit ports.
// Assumes: All status inputs are on the register clock.
// Notes:   Purely combinational; reserved codes give a low level.
`timescale 1ns/100ps
`default_nettype none
module pin0_source_mux
  import gpio_io_pkg::*;
(
  input  wire logic                source,
  input  wire logic          [2:0] signal_select,
  input  wire logic                software_level,
  input  wire logic          [3:0] port_enable,
  input  wire rx_status_type [3:0] rx_status,
  input  wire logic                frame_sync_signal,
  input  wire tx_status_type [1:0] tx_status,
  input  wire logic          [2:0] source_code,
  output logic                     level
);

  // Per-port lock and pass gathered into vectors
  logic [3:0] lock_vec;
  logic [3:0] pass_vec;
  for (genvar i = 0; i < 4; i++) begin : g_port
    assign lock_vec[i] = rx_status[i].lock;
    assign pass_vec[i] = rx_status[i].pass;
  end

  // Empty enable set gives pass high, lock low
  wire           lock_any  = |(lock_vec & port_enable);
  wire           pass_all  = &(pass_vec | ~port_enable);
  wire rx_status_type rx_sel = rx_status[source_code[1:0]];
  wire tx_status_type tx_sel = tx_status[source_code[0]];
  wire           tx_and    = &(pass_vec | ~tx_sel.rx_select);
  wire           tx_or     = |(pass_vec & tx_sel.rx_select);

  // Receive port selection
  wire rx_level =
      (signal_select[2] == 1'b0)       ? rx_sel.remote_pins[signal_select[1:0]] :
      (signal_select == RXSEL_LOCK)    ? rx_sel.lock :
      (signal_select == RXSEL_PASS)    ? rx_sel.pass :
      (signal_select == RXSEL_FRAME)   ? rx_sel.frame_valid :
                                         rx_sel.line_valid;

  // Device status selection; both pass codes give the same AND
  wire dev_level =
      (signal_select == DEVSEL_VALUE)  ? software_level :
      (signal_select == DEVSEL_LOCK)   ? lock_any :
      (signal_select == DEVSEL_PASSA)  ? pass_all :
      (signal_select == DEVSEL_PASSB)  ? pass_all :
      (signal_select == DEVSEL_SYNC)   ? frame_sync_signal : 1'b0;

  // Transmit port selection; codes 110 and 111 are unlisted and treated as reserved
  wire tx_level =
      (signal_select == TXSEL_PASS_AND) ? tx_and :
      (signal_select == TXSEL_PASS_OR)  ? tx_or :
      (signal_select == TXSEL_FRAME)    ? tx_sel.frame_valid :
      (signal_select == TXSEL_LINE)     ? tx_sel.line_valid :
      (signal_select == TXSEL_SYNCED)   ? tx_sel.synchronized :
      (signal_select == TXSEL_INTR)     ? tx_sel.interrupt : 1'b0;

  // Source selection; the level stays low while the driver is off
  assign level = !source                         ? 1'b0 :
                 (source_code[2] == 1'b0)        ? rx_level :
                 (source_code == SRC_DEVICE)     ? dev_level :
                 (source_code == SRC_RESERVED)   ? 1'b0 : tx_level;

endmodule
`default_nettype wire

// ---- src/gpio_io_voltage_control.sv ----
// Purpose: APB register block for I/O supply level control and general-purpose pins.
// Assumes: pclk at 200 MHz; pins and the detected level are asynchronous.
// Notes:   Receive and transmit status arrive on pclk from neighbouring logic.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module gpio_io_voltage_control
  import gpio_io_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic         [11:0] paddr,
  input  wire logic         [31:0] pwdata,
  output logic              [31:0] prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic          [7:0] pin_in,
  input  wire logic                io_level_detect,
  input  wire rx_status_type [3:0] rx_status,
  input  wire logic                frame_sync_signal,
  input  wire tx_status_type [1:0] tx_status,
  output logic                     pin0_out,
  output logic                     pin0_oe,
  output logic                     io_supply_high,
  output logic               [1:0] io_supply_mode,
  output logic               [3:0] receive_port_enable
);

  // Index decode for the error answer; the read mux compares the indices itself
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == IDX_RX_PORT_CONTROL) || (idx == IDX_IO_VOLTAGE) ||
                (idx == IDX_PIN_LEVEL_STATUS) || (idx == IDX_PIN_INPUT_ENABLE) ||
                (idx == IDX_PIN0_OUTPUT);
  endfunction

  // Software-held fields and the registered pin level status
  logic       high_voltage_io_select;
  logic       supply_detect_override;
  logic [1:0] supply_mode_written;
  logic [7:0] pin_input_enables;
  logic [2:0] pin0_signal_select;
  logic [2:0] pin0_source_select;
  logic       pin0_software_level;
  logic       pin0_drive_enable;
  logic [7:0] pin_level_bits;
  logic [3:0] port_enable_bits;

  // Synchronisers for the asynchronous inputs
  // Only the second flop is read, so a metastable level never reaches the status
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic       detect_meta;
  logic       detect_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta    <= 8'h00;
      pin_sync    <= 8'h00;
      detect_meta <= 1'b0;
      detect_sync <= 1'b0;
    end else begin
      pin_meta    <= pin_in;
      pin_sync    <= pin_meta;
      detect_meta <= io_level_detect;
      detect_sync <= detect_meta;
    end
  end

  // Bus decode; a request completes at the edge where pready is seen high
  wire [9:0] reg_index    = paddr[11:2];
  wire       access_phase = psel & penable;
  wire       next_pready  = access_phase & ~pready;
  wire       complete     = access_phase & pready;
  wire       wr_commit    = complete & pwrite;
  wire       wr_io        = wr_commit & (reg_index == IDX_IO_VOLTAGE);
  wire       wr_in_en     = wr_commit & (reg_index == IDX_PIN_INPUT_ENABLE);
  wire       wr_pin0      = wr_commit & (reg_index == IDX_PIN0_OUTPUT);
  wire       wr_rx_ctl    = wr_commit & (reg_index == IDX_RX_PORT_CONTROL);

  // Effective supply controls: detected level unless software overrides
  // A change of the detected level reaches the supply outputs three edges later
  wire       next_high = supply_detect_override ? high_voltage_io_select
                                                : detect_sync;
  wire [1:0] next_mode = supply_detect_override ? supply_mode_written
                         : (detect_sync ? MODE_HIGH_VOLT : MODE_LOW_VOLT);

  // Reads of the voltage register show the effective values
  wire [7:0] io_read   = {next_high, supply_detect_override, next_mode,
                          IO_VOLTAGE_LOW_BITS};
  wire [7:0] pin0_read = {pin0_signal_select, pin0_source_select,
                          pin0_software_level, pin0_drive_enable};

  // Read mux; unmapped indices read zero
  wire [7:0] read_byte =
      (reg_index == IDX_RX_PORT_CONTROL)  ? {4'h0, port_enable_bits} :
      (reg_index == IDX_IO_VOLTAGE)       ? io_read :
      (reg_index == IDX_PIN_LEVEL_STATUS) ? pin_level_bits :
      (reg_index == IDX_PIN_INPUT_ENABLE) ? pin_input_enables :
      (reg_index == IDX_PIN0_OUTPUT)      ? pin0_read : 8'h00;

  // One wait state, so read data is settled before the master samples it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pready & ~is_mapped(reg_index);
      prdata  <= (next_pready & ~pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  // I/O voltage register fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_voltage_io_select <= 1'b0;
      supply_detect_override <= 1'b0;
      supply_mode_written    <= MODE_LOW_VOLT;
    end else if (wr_io) begin
      high_voltage_io_select <= pwdata[IO_HIGH_SEL_BIT];
      supply_detect_override <= pwdata[IO_OVERRIDE_BIT];
      supply_mode_written    <= pwdata[IO_MODE_LSB +: 2];
    end
  end

  // Input enables and receive port enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_input_enables <= RST_PIN_INPUT_ENABLE;
      port_enable_bits  <= RST_RX_PORT_ENABLE;
    end else begin
      if (wr_in_en) pin_input_enables <= pwdata[7:0];
      if (wr_rx_ctl) port_enable_bits <= pwdata[3:0];
    end
  end

  // Pin 0 output control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_signal_select  <= 3'h0;
      pin0_source_select  <= 3'h0;
      pin0_software_level <= 1'b0;
      pin0_drive_enable   <= 1'b0;
    end else if (wr_pin0) begin
      pin0_signal_select  <= pwdata[PIN0_SELECT_LSB +: 3];
      pin0_source_select  <= pwdata[PIN0_SOURCE_LSB +: 3];
      pin0_software_level <= pwdata[PIN0_LEVEL_BIT];
      pin0_drive_enable   <= pwdata[PIN0_ENABLE_BIT];
    end
  end

  // Live pin status; a disabled input path reads low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_bits <= 8'h00;
    end else begin
      pin_level_bits <= pin_sync & pin_input_enables;
    end
  end

  // Pin 0 level selection
  logic mux_level;
  pin0_source_mux u_mux (
    .source            (pin0_drive_enable),
    .signal_select     (pin0_signal_select),
    .software_level    (pin0_software_level),
    .port_enable       (port_enable_bits),
    .rx_status         (rx_status),
    .frame_sync_signal (frame_sync_signal),
    .tx_status         (tx_status),
    .source_code       (pin0_source_select),
    .level             (mux_level)
  );

  // Registered pin and supply outputs; data is forced low while undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_out            <= 1'b0;
      pin0_oe             <= 1'b0;
      io_supply_high      <= 1'b0;
      io_supply_mode      <= MODE_LOW_VOLT;
      receive_port_enable <= RST_RX_PORT_ENABLE;
    end else begin
      pin0_out            <= pin0_drive_enable & mux_level;
      pin0_oe             <= pin0_drive_enable;
      io_supply_high      <= next_high;
      io_supply_mode      <= next_mode;
      receive_port_enable <= port_enable_bits;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper vectors for the combination checks
  logic [3:0] lock_seen;
  logic [3:0] pass_seen;
  for (genvar k = 0; k < 4; k++) begin : g_chk
    assign lock_seen[k] = rx_status[k].lock;
    assign pass_seen[k] = rx_status[k].pass;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence

  a_bus_one_wait: assert property (s_setup ##1 s_access_wait |=> pready)
    else $error("access phase did not end after one wait cycle");
  a_input_enable_write: assert property (
      s_access_wait ##1 (pready && pwrite && reg_index == IDX_PIN_INPUT_ENABLE)
      |=> pin_input_enables == $past(pwdata[7:0]))
    else $error("input enable write not stored");
  a_detect_follow: assert property (!supply_detect_override
      |=> io_supply_high == $past(detect_sync)
          && io_supply_mode == {2{$past(detect_sync)}})
    else $error("supply controls do not follow detected level");
  a_override_used: assert property (supply_detect_override
      |=> io_supply_high == $past(high_voltage_io_select)
          && io_supply_mode == $past(supply_mode_written))
    else $error("override values not applied");
  // Compared with the raw pins, so a swapped bit or a lost sync stage shows up
  a_status_gated: assert property ($past(presetn, 2)
      |=> pin_level_bits == ($past(pin_in, 3) & $past(pin_input_enables)))
    else $error("pin status does not match gated pins");
  a_drive_off: assert property (!pin0_drive_enable |=> !pin0_oe && !pin0_out)
    else $error("pin 0 driven while disabled");
  a_drive_on: assert property (pin0_drive_enable |=> pin0_oe)
    else $error("pin 0 not driven while enabled");
  a_soft_level: assert property (
      pin0_drive_enable && pin0_source_select == SRC_DEVICE
      && pin0_signal_select == DEVSEL_VALUE |=> pin0_out == $past(pin0_software_level))
    else $error("pin 0 does not carry register level");
  a_rx_lock_pick: assert property (
      pin0_drive_enable && !pin0_source_select[2]
      && pin0_signal_select == RXSEL_LOCK
      |=> pin0_out == $past(rx_status[pin0_source_select[1:0]].lock))
    else $error("receive port lock not routed to pin 0");
  a_lock_or: assert property (
      pin0_drive_enable && pin0_source_select == SRC_DEVICE
      && pin0_signal_select == DEVSEL_LOCK
      |=> pin0_out == $past(|(lock_seen & port_enable_bits)))
    else $error("lock OR over enabled ports wrong");
  a_pass_and: assert property (
      pin0_drive_enable && pin0_source_select == SRC_DEVICE
      && pin0_signal_select == DEVSEL_PASSB
      |=> pin0_out == $past(&(pass_seen | ~port_enable_bits)))
    else $error("pass AND over enabled ports wrong");
  a_tx_pass_and: assert property (
      pin0_drive_enable && pin0_source_select == SRC_TX1
      && pin0_signal_select == TXSEL_PASS_AND
      |=> pin0_out == $past(&(pass_seen | ~tx_status[1].rx_select)))
    else $error("transmit pass AND wrong");
  a_reserved_src: assert property (pin0_source_select == SRC_RESERVED |=> !pin0_out)
    else $error("reserved source drove pin 0 high");

  // Register writes land at the completing edge
  a_rx_enable_write: assert property (
      complete && pwrite && reg_index == IDX_RX_PORT_CONTROL
      |=> port_enable_bits == $past(pwdata[3:0]))
    else $error("receive port enable write not stored");
  a_pin0_write: assert property (
      complete && pwrite && reg_index == IDX_PIN0_OUTPUT
      |=> pin0_drive_enable == $past(pwdata[PIN0_ENABLE_BIT])
          && pin0_source_select == $past(pwdata[PIN0_SOURCE_LSB +: 3]))
    else $error("pin 0 control write not stored");
  // A read of the voltage register reports the detected level unless overridden
  a_read_detected: assert property (
      complete && !pwrite && reg_index == IDX_IO_VOLTAGE && !supply_detect_override
      |-> prdata[7:4] == {$past(detect_sync), 1'b0, {2{$past(detect_sync)}}})
    else $error("voltage register read does not show detected level");

  // Routing of the remote pin, frame sync and transmit interrupt select codes
  a_rx_remote_pick: assert property (
      pin0_drive_enable && !pin0_source_select[2] && !pin0_signal_select[2]
      |=> pin0_out ==
          $past(rx_status[pin0_source_select[1:0]].remote_pins[pin0_signal_select[1:0]]))
    else $error("received remote pin not routed to pin 0");
  a_dev_sync_pick: assert property (
      pin0_drive_enable && pin0_source_select == SRC_DEVICE
      && pin0_signal_select == DEVSEL_SYNC |=> pin0_out == $past(frame_sync_signal))
    else $error("frame sync not routed to pin 0");
  a_tx_intr_pick: assert property (
      pin0_drive_enable && pin0_source_select[2:1] == 2'h3
      && pin0_signal_select == TXSEL_INTR
      |=> pin0_out == $past(tx_status[pin0_source_select[0]].interrupt))
    else $error("transmit interrupt not routed to pin 0");

endmodule
`default_nettype wire

// ---- testbench/pin_partner.sv ----
// Purpose: External sensor logic that drives the eight general-purpose pins.
// Assumes: Pins 1 to 7 are inputs only; pin 0 is shared with the block's driver.
// Notes:   No pull on pin 0, so while the block drives it the sensor stays off.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic [7:0] ext_level,
  input  wire logic       pin0_out,
  input  wire logic       pin0_oe,
  output logic      [7:0] pin_in
);
  // Wire level of pin 0: the block wins while it drives, else the sensor shows
  assign pin_in = {ext_level[7:1], pin0_oe ? pin0_out : ext_level[0]};
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the pin and I/O supply register block.
// Assumes: APB answers within 20 cycles; pin and detect paths settle in 3 edges.
// Notes:   Bus results are checked from a queue by a separate monitor process.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gpio_io_pkg::*;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic         [11:0] paddr = 12'h000;
  logic         [31:0] pwdata = 32'h0;
  logic                fs = 1'b0;
  logic                det = 1'b0;
  logic          [7:0] ext = 8'h00;
  rx_status_type [3:0] rx = '0;
  tx_status_type [1:0] tx = '0;
  wire logic    [31:0] prdata;
  wire logic           pready;
  wire logic           pslverr;
  wire logic           pin0_out;
  wire logic           pin0_oe;
  wire logic           sup_high;
  wire logic     [1:0] sup_mode;
  wire logic     [3:0] rpe;
  wire logic     [7:0] pin_in;
  wire logic     [3:0] lk;
  wire logic     [3:0] ps;
  logic          [8:0] e;
  logic          [7:0] c;
  logic          [7:0] v;
  logic          [8:0] q[$];
  int                  n_errors = 0;
  int                  comparisons = 0;
  int                  seed = 3899;

  assign lk = {rx[3].lock, rx[2].lock, rx[1].lock, rx[0].lock};
  assign ps = {rx[3].pass, rx[2].pass, rx[1].pass, rx[0].pass};

  // 200 MHz register clock
  always #2.5 pclk = ~pclk;

  gpio_io_voltage_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .io_level_detect(det), .rx_status(rx),
    .frame_sync_signal(fs), .tx_status(tx), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
    .io_supply_high(sup_high), .io_supply_mode(sup_mode), .receive_port_enable(rpe));

  pin_partner sensors (.ext_level(ext), .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin_in(pin_in));

  task results;
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; x holds {error, read data} expected at completion
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [8:0] x);
    int i;
    q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("[ERR] %0t no ready", $time);
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Monitor: every completing transfer consumes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      comparisons++;
      if (pslverr !== e[8] || (!pwrite && prdata !== {24'h0, e[7:0]})) begin
        n_errors++;
        $display("[ERR] %0t bus %h err %b expected %h", $time, prdata, pslverr, e);
      end
    end
  end

  // Expected pin 0 level worked out from the control byte and the status inputs
  function automatic logic exp0(input logic [7:0] k, input logic [3:0] en);
    tx_status_type t;
    t = tx[k[2]];
    if (!k[0]) return 1'b0;
    if (!k[4]) begin
      case (k[7:5])
        3'h4: return rx[k[3:2]].lock;
        3'h5: return rx[k[3:2]].pass;
        3'h6: return rx[k[3:2]].frame_valid;
        3'h7: return rx[k[3:2]].line_valid;
        default: return rx[k[3:2]].remote_pins[k[6:5]];
      endcase
    end
    if (k[4:2] == 3'h4) begin
      case (k[7:5])
        3'h0: return k[1];
        3'h1: return |(lk & en);
        3'h2, 3'h3: return &(ps | ~en);
        3'h4: return fs;
        default: return 1'b0;
      endcase
    end
    if (k[4:2] == 3'h5) return 1'b0;
    case (k[7:5])
      3'h0: return &(ps | ~t.rx_select);
      3'h1: return |(ps & t.rx_select);
      3'h2: return t.frame_valid;
      3'h3: return t.line_valid;
      3'h4: return t.synchronized;
      3'h5: return t.interrupt;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and two unmapped places, one read and one written
    apb(0, 12'h030, 8'h00, 9'h00F);
    apb(0, 12'h034, 8'h00, 9'h009);
    apb(0, 12'h03C, 8'h00, 9'h0FF);
    apb(0, 12'h040, 8'h00, 9'h000);
    apb(0, 12'h044, 8'h00, 9'h100);
    apb(1, 12'h048, 8'h5A, 9'h100);
    // Detected level drives select and mode until overridden
    det <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({7'h0, sup_high}, 8'h01);
    chk({6'h0, sup_mode}, 8'h03);
    apb(0, 12'h034, 8'h00, 9'h0B9);
    apb(1, 12'h034, 8'h40, 9'h000);
    apb(0, 12'h034, 8'h00, 9'h049);
    chk({5'h0, sup_high, sup_mode}, 8'h00);
    apb(1, 12'h034, 8'hF0, 9'h000);
    det <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, 12'h034, 8'h00, 9'h0F9);
    chk({5'h0, sup_high, sup_mode}, 8'h07);
    apb(1, 12'h034, 8'h00, 9'h000);
    apb(0, 12'h034, 8'h00, 9'h009);
    // Live pin levels through the input enables; status ignores writes
    repeat (6) begin
      ext <= 8'($random(seed));
      v = 8'($random(seed));
      apb(1, 12'h03C, v, 9'h000);
      apb(1, 12'h038, 8'hA5, 9'h000);
      apb(0, 12'h038, 8'h00, {1'b0, ext & v});
    end
    // Pin 0 sources and selects with random status and port enables
    for (int i = 0; i < 64; i++) begin
      v = 8'($random(seed));
      c[1] = 1'($random(seed));
      c = {i[5:0], c[1], i[2:0] != 3'h3};
      rx <= $random(seed);
      tx <= 16'($random(seed));
      fs <= 1'($random(seed));
      apb(1, 12'h030, {4'h0, v[3:0]}, 9'h000);
      apb(1, 12'h040, c, 9'h000);
      repeat (3) @(posedge pclk);
      chk({4'h0, rpe}, {4'h0, v[3:0]});
      chk({6'h0, pin0_oe, pin0_out}, {6'h0, c[0], exp0(c, v[3:0])});
      apb(0, 12'h040, 8'h00, {1'b0, c});
    end
    results();
  end
endmodule
`default_nettype wire
